// [rtl/rto_core.sv]
`include "rto_map.svh"

module rto_core (
   // Clock and reset
   input  wire logic                   clock,
   input  wire logic                   rst,
   // Instruction stream
   input  wire rto_pkg::rto_instr_t    instr,
   input  wire rto_pkg::rto_fsel_t     file_select,
   input  wire rto_pkg::rto_acc_load_t acc_load,
   // Register contents
   output rto_pkg::rto_regs_t          regs,
   // Status toward the core
   output logic                        executed,
   output logic                        carry_we,
   output logic                        skip_req
);
   import rto_pkg::*;

   // ---------------------------------------------------------------
   // Decode
   // ---------------------------------------------------------------
   logic      op_load_fsel;
   logic      op_copy_comp;
   logic      op_wr_lcd_first;
   logic      op_wr_lcd_second;
   logic      acc_side_we;
   logic      acc_we;
   logic      comp_we;
   logic      lcd_first_we;
   logic      lcd_second_we;
   rto_nib_t  fsel_ext;
   rto_regs_t regs_r;
   rto_regs_t regs_nxt;

   assign op_load_fsel     = instr.valid
                             && (instr.code == `RTO_OP_LOAD_ACC_FROM_FILE_SELECT);
   assign op_copy_comp     = instr.valid
                             && (instr.code == `RTO_OP_COPY_ACC_TO_COMPANION);
   assign op_wr_lcd_first  = instr.valid
                             && (instr.code == `RTO_OP_WRITE_FIRST_DISP_CTRL);
   assign op_wr_lcd_second = instr.valid
                             && (instr.code == `RTO_OP_WRITE_SECOND_DISP_CTRL);
   assign executed         = op_load_fsel
                             || op_copy_comp
                             || op_wr_lcd_first
                             || op_wr_lcd_second;

   // ---------------------------------------------------------------
   // Status toward the core
   // ---------------------------------------------------------------
   assign carry_we = 1'b0;
   assign skip_req = 1'b0;

   // ---------------------------------------------------------------
   // Write enables
   // ---------------------------------------------------------------
   assign fsel_ext      = {`RTO_ZERO2, file_select};
   assign acc_side_we   = acc_load.valid && !executed;
   assign acc_we        = op_load_fsel || acc_side_we;
   assign comp_we       = op_copy_comp;
   assign lcd_first_we  = op_wr_lcd_first;
   assign lcd_second_we = op_wr_lcd_second;

   // ---------------------------------------------------------------
   // Next register values
   // ---------------------------------------------------------------
   always_comb begin
      regs_nxt = regs_r;
      if (op_load_fsel) begin
         regs_nxt.acc = fsel_ext;
      end else if (acc_side_we) begin
         regs_nxt.acc = acc_load.data;
      end
      if (comp_we) begin
         regs_nxt.companion = regs_r.acc;
      end
      if (lcd_first_we) begin
         regs_nxt.lcd_control_first = regs_r.acc;
      end
      if (lcd_second_we) begin
         regs_nxt.lcd_control_second = regs_r.acc;
      end
   end

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         regs_r.acc                <= `RTO_ACC_RST;
         regs_r.companion          <= `RTO_COMP_RST;
         regs_r.lcd_control_first  <= `RTO_LCD1_RST;
         regs_r.lcd_control_second <= `RTO_LCD2_RST;
      end else begin
         regs_r <= regs_nxt;
      end
   end

   assign regs = regs_r;

   // ---------------------------------------------------------------
   // Checks on the accumulator
   // ---------------------------------------------------------------
   fsel_low_load_a : assert property (@(posedge clock) disable iff (rst)
      op_load_fsel
      |=> regs_r.acc[`RTO_FSEL_W-1:0] == $past(file_select))
      else $error("accumulator low bits not loaded from file select");

   acc_high_clear_a : assert property (@(posedge clock) disable iff (rst)
      op_load_fsel
      |=> regs_r.acc[`RTO_NIB_W-1:`RTO_FSEL_W] == `RTO_ZERO2)
      else $error("accumulator high bits not cleared");

   acc_side_load_a : assert property (@(posedge clock) disable iff (rst)
      acc_load.valid && !executed
      |=> regs_r.acc == $past(acc_load.data))
      else $error("accumulator side load lost");

   acc_op_priority_a : assert property (@(posedge clock) disable iff (rst)
      op_load_fsel && acc_load.valid
      |=> regs_r.acc == $past(fsel_ext))
      else $error("side load overrode file select load");

   acc_hold_a : assert property (@(posedge clock) disable iff (rst)
      !op_load_fsel && !acc_load.valid
      |=> $stable(regs_r.acc))
      else $error("accumulator changed without a write");

   acc_kept_a : assert property (@(posedge clock) disable iff (rst)
      op_copy_comp || op_wr_lcd_first || op_wr_lcd_second
      |=> $stable(regs_r.acc))
      else $error("accumulator disturbed by a transfer out");

   acc_side_refused_a : assert property (@(posedge clock) disable iff (rst)
      acc_load.valid && executed && !op_load_fsel
      |=> $stable(regs_r.acc))
      else $error("side load taken during a decoded transfer");

   // ---------------------------------------------------------------
   // Checks on the companion
   // ---------------------------------------------------------------
   companion_copy_a : assert property (@(posedge clock) disable iff (rst)
      op_copy_comp
      |=> (regs_r.companion == $past(regs_r.acc)) && $stable(regs_r.acc))
      else $error("companion copy wrong or accumulator disturbed");

   comp_hold_a : assert property (@(posedge clock) disable iff (rst)
      !op_copy_comp
      |=> $stable(regs_r.companion))
      else $error("companion changed without its instruction");

   comp_only_a : assert property (@(posedge clock) disable iff (rst)
      op_copy_comp
      |=> $stable(regs_r.lcd_control_first) && $stable(regs_r.lcd_control_second))
      else $error("companion copy touched display control");

   comp_one_cycle_a : assert property (@(posedge clock) disable iff (rst)
      op_copy_comp ##1 !instr.valid
      |=> $stable(regs_r.companion))
      else $error("companion copy took more than one cycle");

   // ---------------------------------------------------------------
   // Checks on the display control
   // ---------------------------------------------------------------
   lcd_first_wr_a : assert property (@(posedge clock) disable iff (rst)
      op_wr_lcd_first
      |=> regs_r.lcd_control_first == $past(regs_r.acc))
      else $error("first display control not written");

   lcd_second_wr_a : assert property (@(posedge clock) disable iff (rst)
      op_wr_lcd_second
      |=> (regs_r.lcd_control_second == $past(regs_r.acc)) && $stable(regs_r.acc))
      else $error("second display control wrong or accumulator disturbed");

   lcd_first_hold_a : assert property (@(posedge clock) disable iff (rst)
      !op_wr_lcd_first
      |=> $stable(regs_r.lcd_control_first))
      else $error("first display control changed without its instruction");

   lcd_second_hold_a : assert property (@(posedge clock) disable iff (rst)
      !op_wr_lcd_second
      |=> $stable(regs_r.lcd_control_second))
      else $error("second display control changed without its instruction");

   lcd_first_only_a : assert property (@(posedge clock) disable iff (rst)
      op_wr_lcd_first
      |=> $stable(regs_r.lcd_control_second) && $stable(regs_r.companion))
      else $error("first display write touched another register");

   lcd_second_only_a : assert property (@(posedge clock) disable iff (rst)
      op_wr_lcd_second
      |=> $stable(regs_r.lcd_control_first) && $stable(regs_r.companion))
      else $error("second display write touched another register");

   // ---------------------------------------------------------------
   // Checks on status
   // ---------------------------------------------------------------
   no_side_effect_a : assert property (@(posedge clock) disable iff (rst)
      executed
      |-> !carry_we && !skip_req)
      else $error("carry or skip touched");

   status_quiet_a : assert property (@(posedge clock) disable iff (rst)
      1'b1
      |-> !carry_we && !skip_req)
      else $error("carry or skip request raised");

   decode_single_a : assert property (@(posedge clock) disable iff (rst)
      instr.valid
      |-> $onehot0({op_load_fsel, op_copy_comp, op_wr_lcd_first, op_wr_lcd_second}))
      else $error("more than one transfer decoded");

   undecoded_inert_a : assert property (@(posedge clock) disable iff (rst)
      instr.valid && !executed && !acc_load.valid
      |=> $stable(regs_r))
      else $error("undecoded code changed a register");

endmodule // rto_core

// [rtl/rto_map.svh]
`ifndef RTO_MAP_SVH
`define RTO_MAP_SVH

// ---------------------------------------------------------------
// Instruction codes
// ---------------------------------------------------------------
`define RTO_OP_LOAD_ACC_FROM_FILE_SELECT  10'h053
`define RTO_OP_COPY_ACC_TO_COMPANION      10'h00E
`define RTO_OP_WRITE_FIRST_DISP_CTRL      10'h2A8
`define RTO_OP_WRITE_SECOND_DISP_CTRL     10'h2A9

// ---------------------------------------------------------------
// Widths and reset values
// ---------------------------------------------------------------
`define RTO_CODE_W      10
`define RTO_NIB_W       4
`define RTO_FSEL_W      2
`define RTO_ACC_RST     4'h0
`define RTO_COMP_RST    4'h0
`define RTO_LCD1_RST    4'h0
`define RTO_LCD2_RST    4'h0
`define RTO_ZERO2       2'h0

`endif

// [rtl/rto_pkg.sv]
`include "rto_map.svh"

package rto_pkg;
   typedef logic [`RTO_CODE_W-1:0] rto_code_t;
   typedef logic [`RTO_NIB_W-1:0]  rto_nib_t;
   typedef logic [`RTO_FSEL_W-1:0] rto_fsel_t;

   // Instruction presented by the core for one instruction cycle
   typedef struct packed {
      logic      valid;
      rto_code_t code;
   } rto_instr_t;

   // Load of the accumulator by other instructions
   typedef struct packed {
      logic     valid;
      rto_nib_t data;
   } rto_acc_load_t;

   // Registers held by the block
   typedef struct packed {
      rto_nib_t acc;
      rto_nib_t companion;
      rto_nib_t lcd_control_first;
      rto_nib_t lcd_control_second;
   } rto_regs_t;
endpackage

// [tb/tb_top.sv]
`include "rto_map.svh"

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import rto_pkg::*;
   logic          clock;
   logic          rst;
   logic          executed;
   logic          carry_we;
   logic          skip_req;
   rto_instr_t    instr;
   rto_fsel_t     file_select;
   rto_acc_load_t acc_load;
   rto_regs_t     regs;
   int            miscompares;
   int            total_checks;

   rto_core dut (.clock(clock), .rst(rst), .instr(instr), .file_select(file_select),
                 .acc_load(acc_load), .regs(regs), .executed(executed),
                 .carry_we(carry_we), .skip_req(skip_req));

   initial begin
      clock = 1'b0;
      forever #2.5 clock = ~clock;
   end

   task automatic chk(input string what, input logic [3:0] e, input logic [3:0] s);
      total_checks++;
      if (s !== e) begin
         miscompares++;
         $display("mismatch %s expected %h seen %h", what, e, s);
      end
   endtask

   // One instruction cycle; status judged before its edge, regs after it
   task automatic issue(input logic v, input rto_code_t c, input rto_fsel_t f,
                        input logic lv, input rto_nib_t ld, input logic ex);
      @(negedge clock);
      instr = {v, c};
      file_select = f;
      acc_load = {lv, ld};
      #1;
      chk("executed", {3'h0, ex}, {3'h0, executed});
      chk("carry_skip", 4'h0, {2'h0, carry_we, skip_req});
      @(posedge clock);
      #1;
   endtask

   // Load from file select over a full accumulator, side load refused
   task automatic t_load;
      issue(1'b0, 10'h000, 2'h0, 1'b1, 4'hF, 1'b0);
      chk("acc", 4'hF, regs.acc);
      issue(1'b1, `RTO_OP_LOAD_ACC_FROM_FILE_SELECT, 2'h2, 1'b1, 4'h5, 1'b1);
      chk("acc", 4'h2, regs.acc);
      issue(1'b1, `RTO_OP_LOAD_ACC_FROM_FILE_SELECT, 2'h3, 1'b0, 4'h0, 1'b1);
      chk("acc", 4'h3, regs.acc);
   endtask

   // Copy to companion, accumulator kept
   task automatic t_copy;
      issue(1'b1, `RTO_OP_COPY_ACC_TO_COMPANION, 2'h1, 1'b1, 4'h9, 1'b1);
      chk("companion", 4'h3, regs.companion);
      chk("acc", 4'h3, regs.acc);
   endtask

   // Back-to-back display control writes, then an undecoded code
   task automatic t_lcd;
      issue(1'b0, 10'h000, 2'h0, 1'b1, 4'hA, 1'b0);
      issue(1'b1, `RTO_OP_WRITE_FIRST_DISP_CTRL, 2'h0, 1'b0, 4'h0, 1'b1);
      chk("lcd1", 4'hA, regs.lcd_control_first);
      issue(1'b1, `RTO_OP_WRITE_SECOND_DISP_CTRL, 2'h0, 1'b1, 4'h6, 1'b1);
      chk("lcd2", 4'hA, regs.lcd_control_second);
      chk("acc", 4'hA, regs.acc);
      issue(1'b1, 10'h054, 2'h1, 1'b0, 4'h0, 1'b0);
      chk("acc", 4'hA, regs.acc);
      chk("companion", 4'h3, regs.companion);
      chk("lcd1", 4'hA, regs.lcd_control_first);
      chk("lcd2", 4'hA, regs.lcd_control_second);
      issue(1'b0, 10'h000, 2'h0, 1'b0, 4'h0, 1'b0);
   endtask

   // Reset in mid-run clears every register
   task automatic t_reset;
      @(negedge clock);
      rst = 1'b1;
      repeat (2) @(negedge clock);
      rst = 1'b0;
      chk("acc_rst", 4'h0, regs.acc);
      chk("comp_rst", 4'h0, regs.companion);
      chk("lcd1_rst", 4'h0, regs.lcd_control_first);
      chk("lcd2_rst", 4'h0, regs.lcd_control_second);
      issue(1'b1, `RTO_OP_COPY_ACC_TO_COMPANION, 2'h0, 1'b0, 4'h0, 1'b1);
      chk("companion", 4'h0, regs.companion);
   endtask

   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask

   initial begin
      miscompares = 0;
      total_checks = 0;
      rst = 1'b1;
      instr = '0;
      file_select = '0;
      acc_load = '0;
      repeat (8) @(posedge clock);
      @(negedge clock);
      rst = 1'b0;
      chk("reset", 4'h0, regs.acc | regs.companion | regs.lcd_control_first
                         | regs.lcd_control_second);
      t_load();
      t_copy();
      t_lcd();
      t_reset();
      report_and_stop();
   end
endmodule // tb_top
